// ==== verilog/psc_pkg.sv ====
// Notes on behaviour
// - Each 32-bit word goes to one of four registers picked by bits 1:0.
// - Word 2 bit 2 sets pump polarity: zero positive, one negative current.
// - Word 2 bit 3 set presets pump output to half supply.
// - Word 2 bits 7:4 are the pump current code, default 1010.
// - Word 2 bits 9:8 pick detector pulse width 1.5, 3, 4.5, 6 ns.
// - Word 2 bits 12:10 pick the feedback prescaler for the detector.
// - Select codes 000..111 divide by 1,2,3,4,6,8,16,8; default 101.
// - Word 2 bits 27:13 hold five output pair prescaler selects, ascending.
// - Word 2 bit 28 low enters power down; high is normal.
// - Word 2 bit 29 makes shared pin divider reset at zero, hold at one.
// - Word 2 bit 30 low resets all dividers like the reset pin.
// - Word 2 bit 31 low floats the pump output like the hold pin.
// - Word 3 bits 3:2 select the lock window, default 01.
// - Word 3 bits 5:4 select successive in-window events for lock, default 10.
// - Event codes need 1, 16, 64, 256 events; one failure drops lock.
// - Word 3 bit 6 also drops lock whenever a frequency offset is seen.
// - Word 3 bit 9 enables frequency hold-over.
// - Word 3 bit 11 forces hold on; else hold follows analog lock.
// - Test mode only when word 3 bit 16 is one; host zeroes reserved bits.
// - Word 3 bit 28 passes detector inputs to the status outputs.
// - Reference divider ratio is ten-bit code plus one, 1 to 1024.
// - Feedback divider ratio is twelve-bit code plus one, 1 to 4096.
// - Quarter shift replaces divide by 16 per pair; both bits means no shift.
// - Single-ended mode codes: active, high impedance, inverted, low.
// - Differential pair uses only its first output's low mode bit.
// - Delay codes give 0 to 1750 ps; reference lags, feedback leads.
`default_nettype none
package psc_pkg;
  localparam int WORD_W = 32;
  localparam logic [31:0] WORD0_RST = 32'h0007F1FC;
  localparam logic [31:0] WORD1_RST = 32'h0000007D;
  localparam logic [31:0] WORD2_RST = 32'hDB6DB4A2;
  localparam logic [31:0] WORD3_RST = 32'h00000027;
  localparam int SEL_LSB = 0;
  localparam int M_LSB = 2;
  localparam int N_LSB = 12;
  localparam int DLYM_LSB = 24;
  localparam int DLYN_LSB = 27;
  localparam int DIFF_LSB = 2;
  localparam int MODE_LSB = 7;
  localparam int Q4_BIT = 30;
  localparam int Q8_BIT = 31;
  localparam int POL_BIT = 2;
  localparam int PRESET_BIT = 3;
  localparam int CUR_LSB = 4;
  localparam int PW_LSB = 8;
  localparam int FBSEL_LSB = 10;
  localparam int OSEL_LSB = 13;
  localparam int PD_BIT = 28;
  localparam int PINFN_BIT = 29;
  localparam int DRST_BIT = 30;
  localparam int HOLD_BIT = 31;
  localparam int LW_LSB = 2;
  localparam int LC_LSB = 4;
  localparam int OFFSET_ONLY_UNLOCK_MODE_BIT = 6;
  localparam int HOLDOVER_ENABLE_BIT = 9;
  localparam int HTRIG_BIT = 11;
  localparam int TEST_BIT = 16;
  localparam int PASS_BIT = 28;
  localparam logic [8:0] LOCK_N0 = 9'h001;
  localparam logic [8:0] LOCK_N1 = 9'h010;
  localparam logic [8:0] LOCK_N2 = 9'h040;
  localparam logic [8:0] LOCK_N3 = 9'h100;
  localparam int PAIRS = 5;
  typedef struct packed {
    logic sclk;
    logic data;
    logic latch;
  } psc_serial_t;
  typedef struct packed {
    logic polarity;
    logic midrail_preset;
    logic [3:0] current;
    logic [1:0] pulse_width;
    logic hiz;
  } psc_pump_t;
  typedef struct packed {
    logic [1:0] window;
    logic [8:0] required;
    logic offset_only;
    logic holdover_enable;
    logic trigger_select;
    logic test_mode;
    logic passthrough;
  } psc_lock_t;
endpackage
`default_nettype wire

// ==== verilog/psc_config.sv ====
`default_nettype none
module psc_config (
  input wire logic clk,
  input wire logic rst_b,
  input wire psc_pkg::psc_serial_t serial_in,
  input wire logic shared_pin_n,
  input wire logic detector_ref_in,
  input wire logic detector_fb_in,
  input wire logic in_window_in,
  input wire logic freq_offset_in,
  input wire logic analog_lock_in,
  output psc_pkg::psc_pump_t pump_cfg,
  output psc_pkg::psc_lock_t lock_cfg,
  output logic power_down_n,
  output logic divider_reset,
  output logic [10:0] ref_ratio,
  output logic [12:0] fb_ratio,
  output logic [4:0] fb_prescale,
  output logic fb_quarter_shift,
  output logic [4:0][4:0] pair_prescale,
  output logic [4:0] pair_quarter_shift,
  output logic [4:0] pair_differential_select,
  output logic [9:0][1:0] output_mode,
  output logic [10:0] reference_delay_ps,
  output logic [10:0] feedback_delay_ps,
  output logic pll_lock,
  output logic hold_active,
  output logic reference_status_out,
  output logic oscillator_status_out
);
  import psc_pkg::*;

  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [5:0] pin1;
  logic [5:0] pin2;
  logic sclk_prev;
  logic latch_prev;
  logic ref_prev;
  logic [31:0] shift_q;
  logic [31:0] word_q [4];
  logic [8:0] lock_cnt;
  logic commit;
  logic sclk_rise;
  logic ref_edge;
  logic pin_s;
  logic ref_s;
  logic fb_s;
  logic win_s;
  logic offset_only_unlock_mode_s;
  logic alock_s;
  logic [1:0] sel;

  function automatic logic [4:0] ratio_of(input logic [2:0] code,
                                          input logic q4,
                                          input logic q8);
    logic [4:0] r;
    r = 5'h08;
    case (code)
      3'h0: r = 5'h01;
      3'h1: r = 5'h02;
      3'h2: r = 5'h03;
      3'h3: r = 5'h04;
      3'h4: r = 5'h06;
      3'h5: r = 5'h08;
      3'h6: r = (q4 ^ q8) ? (q4 ? 5'h04 : 5'h08) : 5'h10;
      default: r = 5'h08;
    endcase
    return r;
  endfunction

  function automatic logic [10:0] delay_of(input logic [2:0] code);
    logic [10:0] d;
    d = 11'h000;
    case (code)
      3'h0: d = 11'd0;
      3'h1: d = 11'd160;
      3'h2: d = 11'd320;
      3'h3: d = 11'd480;
      3'h4: d = 11'd830;
      3'h5: d = 11'd1130;
      3'h6: d = 11'd1450;
      default: d = 11'd1750;
    endcase
    return d;
  endfunction

  // Pin synchronisers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= 3'h7;
      sync2 <= 3'h7;
      pin1 <= 6'h01;
      pin2 <= 6'h01;
    end else begin
      sync1 <= serial_in;
      sync2 <= sync1;
      pin1 <= {analog_lock_in, freq_offset_in, in_window_in,
               detector_fb_in, detector_ref_in, shared_pin_n};
      pin2 <= pin1;
    end
  end

  assign pin_s = pin2[0];
  assign ref_s = pin2[1];
  assign fb_s = pin2[2];
  assign win_s = pin2[3];
  assign offset_only_unlock_mode_s = pin2[4];
  assign alock_s = pin2[5];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_prev <= 1'b1;
      latch_prev <= 1'b1;
      ref_prev <= 1'b0;
    end else begin
      sclk_prev <= sync2[2];
      latch_prev <= sync2[0];
      ref_prev <= ref_s;
    end
  end

  assign sclk_rise = sync2[2] & ~sclk_prev & ~sync2[0];
  assign commit = sync2[0] & ~latch_prev;
  assign ref_edge = ref_s & ~ref_prev;
  assign sel = shift_q[SEL_LSB +: 2];

  // Serial shift, most significant bit first
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_q <= 32'h00000000;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[30:0], sync2[1]};
    end
  end

  // Word storage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      word_q[0] <= WORD0_RST;
      word_q[1] <= WORD1_RST;
      word_q[2] <= WORD2_RST;
      word_q[3] <= WORD3_RST;
    end else if (commit) begin
      word_q[sel] <= shift_q;
    end
  end

  // Pump and divider control
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pump_cfg <= '0;
      power_down_n <= 1'b1;
      divider_reset <= 1'b0;
    end else begin
      pump_cfg.polarity <= word_q[2][POL_BIT];
      pump_cfg.midrail_preset <= word_q[2][PRESET_BIT];
      pump_cfg.current <= word_q[2][CUR_LSB +: 4];
      pump_cfg.pulse_width <= word_q[2][PW_LSB +: 2];
      pump_cfg.hiz <= ~word_q[2][HOLD_BIT] |
                      (word_q[2][PINFN_BIT] & ~pin_s);
      power_down_n <= word_q[2][PD_BIT];
      divider_reset <= ~word_q[2][DRST_BIT] |
                       (~word_q[2][PINFN_BIT] & ~pin_s);
    end
  end

  // Dividers and delays
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_ratio <= '0;
      fb_ratio <= '0;
      fb_prescale <= '0;
      fb_quarter_shift <= 1'b0;
      reference_delay_ps <= '0;
      feedback_delay_ps <= '0;
    end else begin
      ref_ratio <= {1'b0, word_q[0][M_LSB +: 10]} + 11'h001;
      fb_ratio <= {1'b0, word_q[0][N_LSB +: 12]} + 13'h0001;
      fb_prescale <= ratio_of(word_q[2][FBSEL_LSB +: 3],
                              word_q[1][Q4_BIT], word_q[1][Q8_BIT]);
      fb_quarter_shift <= (word_q[2][FBSEL_LSB +: 3] == 3'h6) &
                          (word_q[1][Q4_BIT] ^ word_q[1][Q8_BIT]);
      reference_delay_ps <= delay_of(word_q[0][DLYM_LSB +: 3]);
      feedback_delay_ps <= delay_of(word_q[0][DLYN_LSB +: 3]);
    end
  end

  // Per pair prescaler and output mode
  for (genvar i = 0; i < PAIRS; i++) begin : g_pair
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        pair_prescale[i] <= '0;
        pair_quarter_shift[i] <= 1'b0;
        pair_differential_select[i] <= 1'b0;
        output_mode[2*i] <= '0;
        output_mode[2*i+1] <= '0;
      end else begin
        pair_prescale[i] <= ratio_of(word_q[2][OSEL_LSB+3*i +: 3],
                                     word_q[1][Q4_BIT], word_q[1][Q8_BIT]);
        pair_quarter_shift[i] <= (word_q[2][OSEL_LSB+3*i +: 3] == 3'h6) &
                                 (word_q[1][Q4_BIT] ^ word_q[1][Q8_BIT]);
        pair_differential_select[i] <= word_q[1][DIFF_LSB+i];
        if (word_q[1][DIFF_LSB+i]) begin
          output_mode[2*i] <= {1'b0, word_q[1][MODE_LSB+4*i]};
          output_mode[2*i+1] <= {1'b0, word_q[1][MODE_LSB+4*i]};
        end else begin
          output_mode[2*i] <= word_q[1][MODE_LSB+4*i +: 2];
          output_mode[2*i+1] <= word_q[1][MODE_LSB+4*i+2 +: 2];
        end
      end
    end
  end

  // Lock configuration
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_cfg <= '0;
    end else begin
      lock_cfg.window <= word_q[3][LW_LSB +: 2];
      case (word_q[3][LC_LSB +: 2])
        2'h0: lock_cfg.required <= LOCK_N0;
        2'h1: lock_cfg.required <= LOCK_N1;
        2'h2: lock_cfg.required <= LOCK_N2;
        default: lock_cfg.required <= LOCK_N3;
      endcase
      lock_cfg.offset_only <= word_q[3][OFFSET_ONLY_UNLOCK_MODE_BIT];
      lock_cfg.holdover_enable <= word_q[3][HOLDOVER_ENABLE_BIT];
      lock_cfg.trigger_select <= word_q[3][HTRIG_BIT];
      lock_cfg.test_mode <= word_q[3][TEST_BIT];
      lock_cfg.passthrough <= word_q[3][PASS_BIT];
    end
  end

  // Digital lock detector, counted on reference edges
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_cnt <= '0;
      pll_lock <= 1'b0;
    end else if (lock_cfg.offset_only && offset_only_unlock_mode_s) begin
      lock_cnt <= '0;
      pll_lock <= 1'b0;
    end else if (ref_edge) begin
      if (!win_s) begin
        lock_cnt <= '0;
        pll_lock <= 1'b0;
      end else if (lock_cnt + 9'h001 >= lock_cfg.required) begin
        lock_cnt <= lock_cfg.required;
        pll_lock <= 1'b1;
      end else begin
        lock_cnt <= lock_cnt + 9'h001;
      end
    end
  end

  // Hold-over and status outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_active <= 1'b0;
      reference_status_out <= 1'b0;
      oscillator_status_out <= 1'b0;
    end else begin
      hold_active <= lock_cfg.holdover_enable &
                     (lock_cfg.trigger_select | alock_s);
      reference_status_out <= lock_cfg.passthrough ? ref_s : pll_lock;
      oscillator_status_out <= lock_cfg.passthrough ? fb_s : 1'b0;
    end
  end

  sequence s_commit(logic [1:0] w);
    commit && sel == w;
  endsequence

  a_word_route: assert property (@(posedge clk) disable iff (!rst_b)
    s_commit(2'h2) |=> word_q[2] == $past(shift_q))
    else $error("word not routed to selected register");
  a_others_kept: assert property (@(posedge clk) disable iff (!rst_b)
    s_commit(2'h3) |=> word_q[0] == $past(word_q[0]) && word_q[2] == $past(word_q[2]))
    else $error("unselected register changed");
  a_pump_polarity: assert property (@(posedge clk) disable iff (!rst_b)
    s_commit(2'h2) ##1 !commit |=> pump_cfg.polarity == $past(shift_q[POL_BIT], 2))
    else $error("pump polarity not taken from word");
  a_ref_ratio: assert property (@(posedge clk) disable iff (!rst_b)
    s_commit(2'h0) ##1 !commit |=> ref_ratio == {1'b0, $past(shift_q[11:2], 2)} + 11'h001)
    else $error("reference ratio not code plus one");
  a_lock_drop: assert property (@(posedge clk) disable iff (!rst_b)
    ref_edge && !win_s |=> !pll_lock)
    else $error("lock kept after failing event");
  a_lock_single: assert property (@(posedge clk) disable iff (!rst_b)
    ref_edge && win_s && !offset_only_unlock_mode_s && lock_cfg.required == LOCK_N0 |=> pll_lock)
    else $error("single event lock not declared");
  a_offset_unlock: assert property (@(posedge clk) disable iff (!rst_b)
    lock_cfg.offset_only && offset_only_unlock_mode_s |=> !pll_lock)
    else $error("offset did not drop lock");
  a_hold_forced: assert property (@(posedge clk) disable iff (!rst_b)
    lock_cfg.holdover_enable && lock_cfg.trigger_select |=> hold_active)
    else $error("forced hold not active");
  a_div_reset: assert property (@(posedge clk) disable iff (!rst_b)
    !word_q[2][DRST_BIT] |=> divider_reset)
    else $error("divider reset bit ignored");
  a_pump_hiz: assert property (@(posedge clk) disable iff (!rst_b)
    !word_q[2][HOLD_BIT] |=> pump_cfg.hiz)
    else $error("pump not floated");
endmodule
`default_nettype wire

// ==== verilog/psc_dummy_unused.sv ====
`default_nettype none
`default_nettype wire

// ==== tb/psc_host.sv ====
`default_nettype none
module psc_host (
  input wire logic clk,
  output psc_pkg::psc_serial_t ser
);
  timeunit 1ns;
  timeprecision 1ns;
  import psc_pkg::*;
  initial ser = '{sclk: 1'b0, data: 1'b1, latch: 1'b1};
  // One word, MSB first, sclk period 16 clk; data inverted once released
  task automatic send(input logic [31:0] w);
    @(negedge clk);
    ser.latch <= 1'b0;
    repeat (8) @(negedge clk);
    for (int i = 31; i >= 0; i--) begin
      ser.data <= w[i];
      repeat (4) @(negedge clk);
      ser.sclk <= 1'b1;
      repeat (8) @(negedge clk);
      ser.sclk <= 1'b0;
      repeat (4) @(negedge clk);
    end
    ser.latch <= 1'b1;
    repeat (4) @(negedge clk);
    ser.data <= ~w[0];
    repeat (8) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ==== tb/psc_config_tb.sv ====
`default_nettype none
module psc_config_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import psc_pkg::*;
  logic clk = 0, rst_b = 0, spin_n = 1, dref = 0, dfb = 0;
  logic inwin = 0, offset_only_unlock_mode = 0, alock = 0;
  psc_serial_t ser;
  psc_pump_t pump;
  psc_lock_t lk;
  logic pdn, drst, fbq, lock, hold, rso, oso;
  logic [10:0] mr, rd, fd;
  logic [12:0] nr;
  logic [4:0] fbp, pq, pds;
  logic [4:0][4:0] pp;
  logic [9:0][1:0] om;
  int errors = 0, compares = 0;
  int tbl [8] = '{1, 2, 3, 4, 6, 8, 16, 8};
  always #5 clk = ~clk;
  psc_host psc_host_inst (.clk(clk), .ser(ser));
  psc_config psc_config_inst (.clk(clk), .rst_b(rst_b), .serial_in(ser),
    .shared_pin_n(spin_n), .detector_ref_in(dref), .detector_fb_in(dfb),
    .in_window_in(inwin), .freq_offset_in(offset_only_unlock_mode), .analog_lock_in(alock),
    .pump_cfg(pump), .lock_cfg(lk), .power_down_n(pdn), .divider_reset(drst),
    .ref_ratio(mr), .fb_ratio(nr), .fb_prescale(fbp), .fb_quarter_shift(fbq),
    .pair_prescale(pp), .pair_quarter_shift(pq), .pair_differential_select(pds),
    .output_mode(om), .reference_delay_ps(rd), .feedback_delay_ps(fd),
    .pll_lock(lock), .hold_active(hold), .reference_status_out(rso),
    .oscillator_status_out(oso));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task close_out;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task pulse(input logic w);
    inwin = w;
    dref = 1;
    tick(4);
    dref = 0;
    tick(4);
  endtask
  task w3(input logic ps, te, tr, hf, fo, input logic [1:0] c, wn);
    psc_host_inst.send({3'b0, ps, 11'b0, te, 4'b0, tr, 1'b0, hf, 2'b0, fo, c, wn, 2'b11});
  endtask
  task t_defaults;
    chk("m", 128, mr);
    chk("n", 128, nr);
    chk("cur", 4'hA, pump.current);
    chk("pw", 0, pump.pulse_width);
    chk("fbp", 8, fbp);
    chk("req", 64, lk.required);
    chk("win", 1, lk.window);
    chk("pdn", 1, pdn);
    chk("drst", 0, drst);
    chk("hiz", 0, pump.hiz);
  endtask
  task t_word0;
    psc_host_inst.send({2'b00, 3'd5, 3'd7, 12'hFFF, 10'h000, 2'b00});
    chk("m", 1, mr);
    chk("n", 4096, nr);
    chk("rd", 1750, rd);
    chk("fd", 1130, fd);
    chk("cur", 4'hA, pump.current);
  endtask
  task t_select;
    logic [31:0] w;
    for (int c = 0; c < 8; c++) begin
      w = WORD2_RST;
      w[12:10] = 3'(c);
      for (int i = 0; i < 5; i++) w[13 + 3 * i +: 3] = 3'((c + i) % 8);
      psc_host_inst.send(w);
      chk("fbp", tbl[c], fbp);
      for (int i = 0; i < 5; i++) chk("pp", tbl[(c + i) % 8], pp[i]);
    end
  endtask
  task t_pump;
    psc_host_inst.send({4'h0, WORD2_RST[27:10], 2'b11, 4'h5, 2'b11, 2'b10});
    chk("pol", 1, pump.polarity);
    chk("pre", 1, pump.midrail_preset);
    chk("cur", 5, pump.current);
    chk("pw", 3, pump.pulse_width);
    chk("pdn", 0, pdn);
    chk("drst", 1, drst);
    chk("hiz", 1, pump.hiz);
    chk("req", 64, lk.required);
    for (int f = 0; f < 2; f++) begin
      psc_host_inst.send({2'b11, 1'(f), 1'b1, WORD2_RST[27:0]});
      spin_n = 0;
      tick(6);
      chk("drst", f == 0, drst);
      chk("hiz", f == 1, pump.hiz);
      spin_n = 1;
      tick(6);
      chk("drst", 0, drst);
    end
  endtask
  task t_word1;
    logic [19:0] pat;
    pat = 20'hE4E4E;
    psc_host_inst.send({2'b00, 3'b000, pat, 5'h00, 2'b01});
    chk("om", pat, om);
    psc_host_inst.send({2'b00, 3'b000, pat, 5'h1F, 2'b01});
    chk("pds", 5'h1F, pds);
    for (int i = 0; i < 5; i++) chk("oma", pat[4 * i], om[2 * i][0]);
    psc_host_inst.send({WORD2_RST[31:16], 3'b110, 3'b110, WORD2_RST[9:0]});
    for (int k = 1; k < 4; k++) begin
      psc_host_inst.send({2'(k), 3'b000, pat, 5'h00, 2'b01});
      chk("fbp", k == 1 ? 4 : k == 2 ? 8 : 16, fbp);
      chk("fbq", k != 3, fbq);
      chk("pq0", k != 3, pq[0]);
      chk("pp0", k == 1 ? 4 : k == 2 ? 8 : 16, pp[0]);
    end
  endtask
  task t_lock;
    w3(1, 1, 0, 1, 1, 2'b00, 2'b11);
    chk("win", 3, lk.window);
    chk("req", 1, lk.required);
    chk("fo", 1, lk.offset_only);
    chk("hf", 1, lk.holdover_enable);
    chk("tr", 0, lk.trigger_select);
    chk("tm", 1, lk.test_mode);
    chk("pt", 1, lk.passthrough);
    pulse(1);
    chk("lock", 1, lock);
    offset_only_unlock_mode = 1;
    tick(6);
    chk("lock", 0, lock);
    offset_only_unlock_mode = 0;
    pulse(1);
    pulse(0);
    chk("lock", 0, lock);
    chk("hold", 0, hold);
    alock = 1;
    tick(6);
    chk("hold", 1, hold);
    alock = 0;
    dref = 1;
    dfb = 1;
    tick(6);
    chk("rso", 1, rso);
    chk("oso", 1, oso);
    dref = 0;
    dfb = 0;
    tick(6);
    w3(0, 0, 1, 1, 0, 2'b01, 2'b01);
    chk("hold", 1, hold);
    chk("oso", 0, oso);
    chk("tm", 0, lk.test_mode);
    pulse(0);
    repeat (15) pulse(1);
    chk("lock", 0, lock);
    pulse(1);
    chk("lock", 1, lock);
    w3(0, 0, 0, 0, 0, 2'b10, 2'b01);
    chk("hold", 0, hold);
    chk("rso", 1, rso);
  endtask
  task t_reset;
    rst_b = 0;
    tick(3);
    rst_b = 1;
    tick(3);
    t_defaults();
    chk("lock", 0, lock);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    close_out();
  end
  initial begin
    tick(12);
    rst_b = 1;
    tick(3);
    t_defaults();
    t_word0();
    t_select();
    t_pump();
    t_word1();
    t_lock();
    t_reset();
    close_out();
  end
endmodule
`default_nettype wire
